//--- src/psr_regs.sv
// Purpose: spare input pin control and playback/record processing select registers
// Assumes: control port delivers one-cycle rd/wr strobes on clk
// Notes: reads answer one cycle after the strobe; reserved bits read as zero
// Operation
// R1 - pin mode 00 disables the pin and powers down its input buffer
// R2 - pin mode 01 enables the pin as secondary clock input
// R3 - pin mode 10 enables general input; live level reads in bit 4
// R4 - host writes zeros to reserved pin bits and the whole reserved register
// R5 - playback code zero routes playback through the programmable engine
// R6 - playback codes 1 to 25 select the matching preset block
// R7 - host never writes playback codes 26 to 31
// R8 - host writes 000 into playback register upper bits
// R9 - record code zero routes record through the record programmable engine
// R10 - record codes 4-6, 10-12, 16-18 select the matching preset block
// R11 - host never writes the reserved record codes
// R12 - host writes 000 into record register upper bits
`timescale 1ns/1ps
module psr_regs (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // control port
    input wire psr_pkg::psr_req_t req,
    output logic [7:0] rdata,
    output logic rvalid,
    // spare input pin
    input wire logic third_input_pin,
    output logic pin_buffer_en,
    output logic pin_clock_use,
    output logic general_purpose_input,
    // processing select
    output psr_pkg::psr_proc_sel_t playback_sel,
    output psr_pkg::psr_proc_sel_t record_sel
);
    logic [1:0] pin_mode_q;
    logic [4:0] play_q;
    logic [4:0] rec_q;
    logic [7:0] rdata_q;
    logic rvalid_q;
    logic buf_en_q;
    logic clk_use_q;
    logic gpin_q;
    psr_pkg::psr_proc_sel_t play_sel_q;
    psr_pkg::psr_proc_sel_t rec_sel_q;
    logic pin_level;

    function automatic logic rec_code_valid(input logic [4:0] c);
        rec_code_valid = (c >= 5'h04 && c <= 5'h06) || (c >= 5'h0A && c <= 5'h0C)
            || (c >= 5'h10 && c <= 5'h12);
    endfunction

    wire wr_pin = req.wr && req.addr == psr_pkg::OFS_PIN_CTRL;
    wire wr_play = req.wr && req.addr == psr_pkg::OFS_PLAY_SEL;
    wire wr_rec = req.wr && req.addr == psr_pkg::OFS_REC_SEL;
    // upper bits and reserved register are not stored; they read as zero [R4] [R8] [R12]
    wire [1:0] pin_mode_d = wr_pin ? req.wdata[6:5] : pin_mode_q;
    wire [4:0] play_d = wr_play ? req.wdata[4:0] : play_q;
    wire [4:0] rec_d = wr_rec ? req.wdata[4:0] : rec_q;
    wire mode_off = pin_mode_q == 2'(psr_pkg::PSR_PIN_OFF);
    wire mode_clk = pin_mode_q == 2'(psr_pkg::PSR_PIN_CLOCK);
    wire mode_gpin = pin_mode_q == 2'(psr_pkg::PSR_PIN_GPIN);
    wire [7:0] pin_reg = {1'b0, pin_mode_q, pin_level & mode_gpin, 4'h0}; // [R3]
    wire [7:0] rd_mux =
        (req.addr == psr_pkg::OFS_PIN_CTRL) ? pin_reg :
        (req.addr == psr_pkg::OFS_PLAY_SEL) ? {3'h0, play_q} :
        (req.addr == psr_pkg::OFS_REC_SEL) ? {3'h0, rec_q} : 8'h00;
    wire play_preset = play_q != 5'h00 && play_q <= psr_pkg::PLAY_SEL_MAX; // [R6] [R7]
    wire rec_preset = rec_code_valid(rec_q); // [R10] [R11]

    psr_pin_sync psr_pin_sync_i (
        .clk(clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .pin_in(third_input_pin),
        .enable(!mode_off),
        .level(pin_level)
    );

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_mode_q <= psr_pkg::RST_PIN_MODE;
            play_q <= psr_pkg::RST_PLAY_SEL;
            rec_q <= psr_pkg::RST_REC_SEL;
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end else if (clk_en) begin
            pin_mode_q <= pin_mode_d;
            play_q <= play_d;
            rec_q <= rec_d;
            rvalid_q <= req.rd;
            rdata_q <= req.rd ? rd_mux : 8'h00;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            buf_en_q <= 1'b0;
            clk_use_q <= 1'b0;
            gpin_q <= 1'b0;
            play_sel_q <= '0;
            rec_sel_q <= '0;
        end else if (clk_en) begin
            buf_en_q <= !mode_off; // [R1]
            clk_use_q <= mode_clk; // [R2]
            gpin_q <= mode_gpin & pin_level; // [R3]
            play_sel_q <= '{use_engine: play_q == 5'h00, preset_block: play_q,
                            preset_valid: play_preset}; // [R5] [R6]
            rec_sel_q <= '{use_engine: rec_q == 5'h00, preset_block: rec_q,
                           preset_valid: rec_preset}; // [R9] [R10]
        end
    end

    assign rdata = rdata_q;
    assign rvalid = rvalid_q;
    assign pin_buffer_en = buf_en_q;
    assign pin_clock_use = clk_use_q;
    assign general_purpose_input = gpin_q;
    assign playback_sel = play_sel_q;
    assign record_sel = rec_sel_q;

    property p_off_powers_down;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && mode_off) |=> !pin_buffer_en;
    endproperty
    a_off_powers_down: assert property (p_off_powers_down) // [R1]
        else $error("buffer on while off");

    property p_clock_mode;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && mode_clk) |=> (pin_clock_use && pin_buffer_en);
    endproperty
    a_clock_mode: assert property (p_clock_mode) else $error("clock use not set"); // [R2]

    sequence s_read_pin;
        req.rd && clk_en && req.addr == psr_pkg::OFS_PIN_CTRL && !mode_gpin;
    endsequence
    property p_level_hidden;
        @(posedge clk) disable iff (!reset_n)
        s_read_pin |=> (rvalid && rdata[4] == 1'b0);
    endproperty
    a_level_hidden: assert property (p_level_hidden) // [R3]
        else $error("level shown outside gpin");

    property p_rsvd_reads_zero;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && req.rd && req.addr == psr_pkg::OFS_RSVD) |=> rdata == 8'h00;
    endproperty
    a_rsvd_reads_zero: assert property (p_rsvd_reads_zero) // [R4]
        else $error("reserved not zero");

    property p_play_engine;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && wr_play && req.wdata[4:0] == 5'h00) ##1 clk_en
            |=> (playback_sel.use_engine && !playback_sel.preset_valid);
    endproperty
    a_play_engine: assert property (p_play_engine) // [R5]
        else $error("playback engine not chosen");

    property p_play_preset;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && wr_play && req.wdata[4:0] == 5'h19) ##1 (clk_en && !wr_play)
            |=> (playback_sel.preset_valid && playback_sel.preset_block == 5'h19);
    endproperty
    a_play_preset: assert property (p_play_preset) else $error("preset 25 not chosen"); // [R6]

    property p_rec_engine;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && rec_q == 5'h00) |=> record_sel.use_engine;
    endproperty
    a_rec_engine: assert property (p_rec_engine) else $error("record engine not chosen"); // [R9]

    property p_rec_preset;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && rec_q == 5'h0B)
            |=> (record_sel.preset_valid && record_sel.preset_block == 5'h0B);
    endproperty
    a_rec_preset: assert property (p_rec_preset) // [R10]
        else $error("record preset 11 not chosen");

    property p_read_latency;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && req.rd && req.addr == psr_pkg::OFS_PLAY_SEL && !req.wr)
            |=> (rvalid && rdata == {3'h0, $past(play_q)});
    endproperty
    a_read_latency: assert property (p_read_latency) // [R6]
        else $error("playback readback wrong");

    // the input output follows the synchronised level only in general input mode
    property p_gpin_follows;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && mode_gpin) |=> general_purpose_input == $past(pin_level);
    endproperty
    a_gpin_follows: assert property (p_gpin_follows) // [R3]
        else $error("input output not following pin");

    property p_off_silent;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && mode_off) |=> (!general_purpose_input && !pin_clock_use);
    endproperty
    a_off_silent: assert property (p_off_silent) // [R1]
        else $error("pin active while off");

    // any stored preset code must reach the playback path unchanged
    property p_play_match;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && play_q inside {[5'h01:psr_pkg::PLAY_SEL_MAX]})
            |=> (playback_sel.preset_valid && !playback_sel.use_engine
            && playback_sel.preset_block == $past(play_q));
    endproperty
    a_play_match: assert property (p_play_match) // [R6]
        else $error("playback preset mismatch");

    property p_play_engine_held;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && play_q == 5'h00)
            |=> (playback_sel.use_engine && !playback_sel.preset_valid);
    endproperty
    a_play_engine_held: assert property (p_play_engine_held) // [R5]
        else $error("playback engine not held");

    property p_rec_match;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && rec_q inside {[5'h04:5'h06], [5'h0A:5'h0C], [5'h10:5'h12]})
            |=> (record_sel.preset_valid && !record_sel.use_engine
            && record_sel.preset_block == $past(rec_q));
    endproperty
    a_rec_match: assert property (p_rec_match) // [R10]
        else $error("record preset mismatch");

    // a read of the pin register in input mode carries the live level
    sequence s_read_gpin;
        req.rd && clk_en && req.addr == psr_pkg::OFS_PIN_CTRL && mode_gpin;
    endsequence
    property p_level_shown;
        @(posedge clk) disable iff (!reset_n)
        s_read_gpin |=> (rvalid && rdata[4] == $past(pin_level));
    endproperty
    a_level_shown: assert property (p_level_shown) // [R3]
        else $error("pin level not read back");
endmodule

//--- src/psr_pkg.sv
// Purpose: shared constants and types for the pin and processing select register bank
// Assumes: 8-bit registers addressed by a 7-bit register number on one page
// Notes: offsets are register numbers on the control port
package psr_pkg;
    localparam int unsigned ADDR_W = 7;
    localparam int unsigned DATA_W = 8;
    localparam logic [6:0] OFS_PIN_CTRL = 7'h3A;
    localparam logic [6:0] OFS_RSVD = 7'h3B;
    localparam logic [6:0] OFS_PLAY_SEL = 7'h3C;
    localparam logic [6:0] OFS_REC_SEL = 7'h3D;
    localparam int unsigned PIN_MODE_LSB = 5;
    localparam int unsigned PIN_LEVEL_BIT = 4;
    localparam logic [1:0] RST_PIN_MODE = 2'h0;
    localparam logic [4:0] RST_PLAY_SEL = 5'h01;
    localparam logic [4:0] RST_REC_SEL = 5'h04;
    localparam logic [4:0] PLAY_SEL_MAX = 5'h19;
    localparam int unsigned SYNC_STAGES = 3;

    typedef enum logic [1:0] {
        PSR_PIN_OFF,
        PSR_PIN_CLOCK,
        PSR_PIN_GPIN,
        PSR_PIN_RSVD
    } psr_pin_mode_t;

    // processing choice towards one audio path
    typedef struct packed {
        logic use_engine;
        logic [4:0] preset_block;
        logic preset_valid;
    } psr_proc_sel_t;

    // register access from the serial control port
    typedef struct packed {
        logic wr;
        logic rd;
        logic [6:0] addr;
        logic [7:0] wdata;
    } psr_req_t;
endpackage

//--- src/psr_pin_sync.sv
// Purpose: three-stage synchroniser for the spare input pin
// Assumes: pin is asynchronous to clk
// Notes: a change is accepted once stages two and three agree
`timescale 1ns/1ps
module psr_pin_sync (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // pin side
    input wire logic pin_in,
    input wire logic enable,
    // result
    output logic level
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic level_q;
    wire agree = (s2_q == s3_q);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            level_q <= 1'b0;
        end else if (clk_en) begin
            s1_q <= pin_in & enable;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (!enable) begin
                level_q <= 1'b0;
            end else if (agree) begin
                level_q <= s3_q;
            end
        end
    end
    assign level = level_q;
endmodule

//--- tb/psr_host.sv
// Purpose: host model issuing register strobes on the control port
// Assumes: one strobe per request, released at the next edge
// Notes: reserved bits are cleared and reserved playback and record codes never sent; pin mode 11 is passed through
`timescale 1ns/1ps
module psr_host (
    // clock
    input wire logic clk,
    // control port
    output psr_pkg::psr_req_t req,
    input wire logic [7:0] rdata,
    input wire logic rvalid
);
    initial req = '0;
    function automatic logic legal(logic [6:0] a, logic [4:0] c);
        if (a == psr_pkg::OFS_PLAY_SEL) return c <= psr_pkg::PLAY_SEL_MAX;
        if (a != psr_pkg::OFS_REC_SEL) return 1'b1;
        return c inside {5'h00, [5'h04:5'h06], [5'h0A:5'h0C], [5'h10:5'h12]};
    endfunction
    function automatic logic [7:0] clean(logic [6:0] a, logic [7:0] d);
        if (a == psr_pkg::OFS_PIN_CTRL) return d & 8'h60;
        if (a == psr_pkg::OFS_RSVD) return 8'h00;
        return d & 8'h1F;
    endfunction
    task automatic write(input logic [6:0] a, input logic [7:0] d);
        if (!legal(a, d[4:0])) return;
        @(posedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: clean(a, d)};
        @(posedge clk);
        req <= '0;
    endtask
    task automatic read(input logic [6:0] a, output logic [7:0] d, output logic v);
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        req <= '0;
        #1;
        d = rdata;
        v = rvalid;
    endtask
endmodule

//--- tb/pin_and_dsp_preset_select_regs_bench.sv
// Purpose: self-checking bench for the pin and processing select registers
// Assumes: host model drives the control port
// Notes: reset held ten cycles, pulsed again at the end; clock enable dropped once
`timescale 1ns/1ps
module pin_and_dsp_preset_select_regs_bench;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic clk_en = 1'b1;
    logic pin = 1'b0;
    psr_pkg::psr_req_t req;
    logic [7:0] rdata;
    logic rvalid, buf_en, clk_use, gpin;
    psr_pkg::psr_proc_sel_t play, rec;
    int n_errors = 0;
    int n_compared = 0;
    psr_regs psr_regs_i (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .req(req),
        .rdata(rdata), .rvalid(rvalid), .third_input_pin(pin), .pin_buffer_en(buf_en),
        .pin_clock_use(clk_use), .general_purpose_input(gpin), .playback_sel(play),
        .record_sel(rec));
    psr_host psr_host_i (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));
    initial begin
        forever #2 clk = ~clk;
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic v;
        psr_host_i.read(a, d, v);
        chk("rvalid", 8'h01, {7'h00, v});
        chk("rdata", exp, d);
    endtask
    task automatic sel_chk(input string what, input logic [4:0] c,
        input psr_pkg::psr_proc_sel_t s);
        if (c == 5'h00) chk(what, 8'h02, {6'h00, s.use_engine, s.preset_valid});
        else chk(what, {2'h0, c, 1'b1}, {1'b0, s});
    endtask
    task automatic t_reset();
        repeat (2) @(posedge clk);
        #1;
        sel_chk("playback_sel", 5'h01, play);
        sel_chk("record_sel", 5'h04, rec);
        chk("pin_outputs", 8'h00, {5'h00, buf_en, clk_use, gpin});
        rd_chk(psr_pkg::OFS_PIN_CTRL, 8'h00);
        rd_chk(psr_pkg::OFS_RSVD, 8'h00);
        rd_chk(psr_pkg::OFS_PLAY_SEL, 8'h01);
        rd_chk(psr_pkg::OFS_REC_SEL, 8'h04);
        rd_chk(7'h00, 8'h00);
    endtask
    task automatic t_pin(input logic lvl);
        logic [1:0] m;
        @(posedge clk);
        pin <= lvl;
        for (int i = 0; i < 4; i++) begin
            m = i[1:0];
            psr_host_i.write(psr_pkg::OFS_PIN_CTRL, {1'b1, m, 5'h1F});
            repeat (8) @(posedge clk);
            #1;
            chk("pin_outputs", {5'h00, m != 2'h0, m == 2'h1, lvl && m == 2'h2},
                {5'h00, buf_en, clk_use, gpin});
            rd_chk(psr_pkg::OFS_PIN_CTRL, {1'b0, m, lvl && m == 2'h2, 4'h0});
        end
    endtask
    task automatic t_play();
        for (int c = 0; c <= 25; c++) begin
            psr_host_i.write(psr_pkg::OFS_PLAY_SEL, {3'h7, c[4:0]});
            rd_chk(psr_pkg::OFS_PLAY_SEL, {3'h0, c[4:0]});
            sel_chk("playback_sel", c[4:0], play);
        end
    endtask
    task automatic t_rec();
        logic [4:0] codes [10] = '{5'h00, 5'h04, 5'h05, 5'h06, 5'h0A, 5'h0B, 5'h0C,
            5'h10, 5'h11, 5'h12};
        foreach (codes[i]) begin
            psr_host_i.write(psr_pkg::OFS_REC_SEL, {3'h7, codes[i]});
            rd_chk(psr_pkg::OFS_REC_SEL, {3'h0, codes[i]});
            sel_chk("record_sel", codes[i], rec);
        end
    endtask
    // a write while the clock enable is low must leave the playback register untouched
    task automatic t_freeze();
        @(posedge clk);
        clk_en <= 1'b0;
        psr_host_i.write(psr_pkg::OFS_PLAY_SEL, 8'h07);
        repeat (2) @(posedge clk);
        #1;
        sel_chk("playback_sel_frozen", 5'h19, play);
        @(posedge clk);
        clk_en <= 1'b1;
        rd_chk(psr_pkg::OFS_PLAY_SEL, 8'h19);
    endtask
    task automatic t_rerun();
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        t_reset();
    endtask
    task automatic summarize();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        t_reset();
        t_pin(1'b1);
        t_pin(1'b0);
        t_play();
        t_freeze();
        t_rec();
        t_rerun();
        summarize();
    end
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        summarize();
    end
endmodule
